// ---- src/interval_timer_pkg.sv ----
// Constants shared by the 12-bit interval timer block and its helpers.
// Assumes a 32-bit APB register bus, one register per aligned word.
package interval_timer_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] OFS_SUB_SUPPLY   = 8'h00; // supply control
    localparam logic [7:0] OFS_SUB_CLK_SEL  = 8'h04; // subsystem source
    localparam logic [7:0] OFS_PERIPH_EN2   = 8'h08; // peripheral enable
    localparam logic [7:0] OFS_IRQ_FLAG     = 8'h0C; // request flag
    localparam logic [7:0] OFS_IRQ_MASK     = 8'h10; // request mask
    localparam logic [7:0] OFS_TIMER_CTRL   = 8'h14; // run and compare
    localparam logic [7:0] OFS_EVT_STATUS   = 8'h18; // sticky events, RO
    localparam logic [7:0] OFS_EVT_CLEAR    = 8'h1C; // write one to clear
    localparam logic [7:0] OFS_EVT_ENABLE   = 8'h20; // event enables
    localparam logic [7:0] OFS_BLOCK_RESET  = 8'h24; // timer block reset
    localparam logic [7:0] OFS_TIMER_COUNT  = 8'h28; // live count, RO

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int BIT_LOW_POWER_SUPPLY = 7;  // supply control
    localparam int BIT_COUNT_CLK_SELECT = 4;  // supply control
    localparam int BIT_SUB_SOURCE       = 0;  // subsystem clock select
    localparam int BIT_TIMER_CLK_GATE   = 7;  // peripheral enable
    localparam int BIT_TIMER_IRQ        = 2;  // flag and mask
    localparam int BIT_TIMER_RUN        = 15; // timer control
    localparam int CMP_MSB              = 11; // compare field top bit
    localparam int BIT_BLOCK_RESET      = 0;  // block reset register
    localparam int EVT_INTERVAL         = 0;  // status: interval hit
    localparam int EVT_CMP_ZERO         = 1;  // status: zero compare run
    localparam int EVT_WIDTH            = 2;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0]  RST_SUB_SUPPLY  = 8'h00;
    localparam logic        RST_SUB_SOURCE  = 1'b0;
    localparam logic        RST_CLK_GATE    = 1'b0;
    localparam logic        RST_IRQ_FLAG    = 1'b0;
    localparam logic        RST_IRQ_MASK    = 1'b1; // masked from reset
    localparam logic [15:0] RST_TIMER_CTRL  = 16'h0000;
    localparam logic        RST_BLOCK_RESET = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Synchronised pin inputs, index into the sync bank
    localparam int PIN_SUB_CLK    = 0;
    localparam int PIN_LOSC_CLK   = 1;
    localparam int PIN_DEEP_STOP  = 2;
    localparam int PIN_HALT       = 3;
    localparam int PIN_CPU_ON_SUB = 4;
    localparam int PIN_COUNT      = 5;

    // APB transfer phase of the slave
    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_ACCESS = 2'b01
    } apb_phase_e;

endpackage

// ---- src/pin_sync_edge.sv ----
// Two-flop synchroniser bank with rising-edge detect on the synced level.
// Assumes inputs are asynchronous pins; the first stage feeds only stage two.
`timescale 1ns/1ps
module pin_sync_edge #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    // Raw pins
    input  wire logic [WIDTH-1:0] i_pin,
    // Synced level and rising-edge pulse
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise
);

    logic [WIDTH-1:0] meta_q;  // First stage, read by stage two only
    logic [WIDTH-1:0] sync_q;  // Second stage, safe to use
    logic [WIDTH-1:0] prev_q;  // Delayed copy for edge detect

    // Synchroniser chain
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign o_level = sync_q;
    // Rising edge seen in the same cycle the synced level rises
    assign o_rise  = sync_q & ~prev_q;

endmodule // pin_sync_edge

// ---- src/interval_timer.sv ----
// 12-bit interval timer with count clock selection, clock gating and an
// interrupt request flag and mask, reached over APB.
// Assumes count clocks are slow pins well below half of i_clk (40 MHz).
//
// Overview of operation
// - Run bit 15 low: counter stopped, cleared
// - Interrupt every compare plus one counts
// - Enable bit 7 gates timer count clock
// - Flag bit 2 set on each request
// - Mask blocks servicing; flag still sets
// - Supply bit 4 picks subsystem or oscillator
// - Low-power bit cuts subsystem clock elsewhere
// - Select bit 0 picks sub clock source
// - Low-power bit 7, stop or halt-on-sub
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
module interval_timer (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Clock pins and power state pins
    input  wire logic        i_sub_clk,
    input  wire logic        i_losc_clk,
    input  wire logic        i_deep_stop,
    input  wire logic        i_halt,
    input  wire logic        i_cpu_on_sub,
    // Interrupt outputs
    output logic             o_interval_interrupt,
    output logic             o_irq,
    // Subsystem clock supply to other peripherals
    output logic             o_periph_sub_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [7:0]  sub_supply_q;        // Supply control register
    logic        sub_source_q;        // Subsystem source select
    logic        timer_clk_gate_q;    // Peripheral enable bit
    logic        timer_irq_flag_q;    // Request flag
    logic        timer_irq_mask_q;    // Request mask
    logic [15:0] timer_ctrl_q;        // Run bit and compare value
    logic        block_reset_q;       // Holds timer logic in reset
    logic [11:0] count_q;             // Running counter
    logic        match_q;             // One-cycle match pulse
    logic [interval_timer_pkg::EVT_WIDTH-1:0] evt_status_q; // Sticky
    logic [interval_timer_pkg::EVT_WIDTH-1:0] evt_enable_q; // Enables
    logic [interval_timer_pkg::EVT_WIDTH-1:0] evt_set;      // New events
    logic [interval_timer_pkg::EVT_WIDTH-1:0] evt_clr;      // Clears

    logic [interval_timer_pkg::PIN_COUNT-1:0] pin_raw;   // Raw pins
    logic [interval_timer_pkg::PIN_COUNT-1:0] pin_lvl;   // Synced levels
    logic [interval_timer_pkg::PIN_COUNT-1:0] pin_rise;  // Rising edges

    logic        subsystem_tick;      // Edge of selected subsystem clock
    logic        count_tick;          // Edge of timer count clock
    logic        timer_run;           // Counter allowed to advance
    logic        wr_en;               // Write takes effect this cycle
    logic        setup;               // APB setup cycle
    logic [31:0] rd_data;             // Read mux
    logic        addr_ok;             // Address is mapped
    logic [11:0] cmp_value;           // Compare field

    ////////////////////////////////////////////////////////////////////////
    // Helper functions

    // Address decode shared by write enable and error answer
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == interval_timer_pkg::OFS_SUB_SUPPLY)  ||
                    (addr == interval_timer_pkg::OFS_SUB_CLK_SEL) ||
                    (addr == interval_timer_pkg::OFS_PERIPH_EN2)  ||
                    (addr == interval_timer_pkg::OFS_IRQ_FLAG)    ||
                    (addr == interval_timer_pkg::OFS_IRQ_MASK)    ||
                    (addr == interval_timer_pkg::OFS_TIMER_CTRL)  ||
                    (addr == interval_timer_pkg::OFS_EVT_STATUS)  ||
                    (addr == interval_timer_pkg::OFS_EVT_CLEAR)   ||
                    (addr == interval_timer_pkg::OFS_EVT_ENABLE)  ||
                    (addr == interval_timer_pkg::OFS_BLOCK_RESET) ||
                    (addr == interval_timer_pkg::OFS_TIMER_COUNT);
    endfunction

    // Register write strobe for one offset
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = wr_en && (i_paddr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    assign pin_raw = {i_cpu_on_sub, i_halt, i_deep_stop,
                      i_losc_clk, i_sub_clk};

    // All pins pass two flops before any logic sees them
    pin_sync_edge #(
        .WIDTH (interval_timer_pkg::PIN_COUNT)
    ) u_pin_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   (pin_raw),
        .o_level (pin_lvl),
        .o_rise  (pin_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Count clock selection

    assign subsystem_tick = sub_source_q
        ? pin_rise[interval_timer_pkg::PIN_LOSC_CLK]
        : pin_rise[interval_timer_pkg::PIN_SUB_CLK];

    // count clock select, clock gate applied
    assign count_tick = timer_clk_gate_q &&
        (sub_supply_q[interval_timer_pkg::BIT_COUNT_CLK_SELECT]
            ? pin_rise[interval_timer_pkg::PIN_LOSC_CLK]
            : subsystem_tick);

    assign cmp_value = timer_ctrl_q[interval_timer_pkg::CMP_MSB:0];

    assign timer_run = timer_ctrl_q[interval_timer_pkg::BIT_TIMER_RUN] &&
                       timer_clk_gate_q && !block_reset_q;

    ////////////////////////////////////////////////////////////////////////
    // APB handshake: setup latches the answer, access shows it

    assign setup = i_psel && !i_penable;
    // A write lands only in the access cycle that sees pready high
    assign wr_en = i_psel && i_penable && o_pready && i_pwrite &&
                   addr_ok;
    assign addr_ok = is_mapped(i_paddr);

    // Ready and error come from flops set in the setup cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= setup;
            // Unmapped address: answered with an error, nothing stored
            o_pslverr <= setup && !is_mapped(i_paddr);
        end
    end

    // Read mux; write-only and unmapped words read as zero
    always_comb begin
        rd_data = '0;
        unique case (i_paddr)
            interval_timer_pkg::OFS_SUB_SUPPLY:
                rd_data[7:0] = sub_supply_q;
            interval_timer_pkg::OFS_SUB_CLK_SEL:
                rd_data[interval_timer_pkg::BIT_SUB_SOURCE] = sub_source_q;
            interval_timer_pkg::OFS_PERIPH_EN2:
                rd_data[interval_timer_pkg::BIT_TIMER_CLK_GATE] =
                    timer_clk_gate_q;
            interval_timer_pkg::OFS_IRQ_FLAG:
                rd_data[interval_timer_pkg::BIT_TIMER_IRQ] =
                    timer_irq_flag_q;
            interval_timer_pkg::OFS_IRQ_MASK:
                rd_data[interval_timer_pkg::BIT_TIMER_IRQ] =
                    timer_irq_mask_q;
            interval_timer_pkg::OFS_TIMER_CTRL:
                rd_data[15:0] = timer_ctrl_q;
            interval_timer_pkg::OFS_EVT_STATUS:
                rd_data[interval_timer_pkg::EVT_WIDTH-1:0] = evt_status_q;
            interval_timer_pkg::OFS_EVT_ENABLE:
                rd_data[interval_timer_pkg::EVT_WIDTH-1:0] = evt_enable_q;
            interval_timer_pkg::OFS_BLOCK_RESET:
                rd_data[interval_timer_pkg::BIT_BLOCK_RESET] =
                    block_reset_q;
            interval_timer_pkg::OFS_TIMER_COUNT:
                rd_data[11:0] = count_q;
            default:
                rd_data = '0;
        endcase
    end

    // Read data captured in setup so it stands through access
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= '0;
        end else if (setup && !i_pwrite) begin
            o_prdata <= rd_data;
        end else begin
            // Stands for the access cycle only, zero after it
            o_prdata <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock control registers

    // Supply control keeps only its two live bits
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sub_supply_q <= interval_timer_pkg::RST_SUB_SUPPLY;
        end else if (wr_hit(interval_timer_pkg::OFS_SUB_SUPPLY)) begin
            sub_supply_q <= '0;
            sub_supply_q[interval_timer_pkg::BIT_LOW_POWER_SUPPLY] <=
                i_pwdata[interval_timer_pkg::BIT_LOW_POWER_SUPPLY];
            sub_supply_q[interval_timer_pkg::BIT_COUNT_CLK_SELECT] <=
                i_pwdata[interval_timer_pkg::BIT_COUNT_CLK_SELECT];
        end
    end

    // Subsystem source; software must not pick the oscillator while the
    // sub clock oscillator runs, the glitch-free switch is its burden
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sub_source_q <= interval_timer_pkg::RST_SUB_SOURCE;
        end else if (wr_hit(interval_timer_pkg::OFS_SUB_CLK_SEL)) begin
            sub_source_q <= i_pwdata[interval_timer_pkg::BIT_SUB_SOURCE];
        end
    end

    // Timer clock gate in the peripheral enable register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_clk_gate_q <= interval_timer_pkg::RST_CLK_GATE;
        end else if (wr_hit(interval_timer_pkg::OFS_PERIPH_EN2)) begin
            timer_clk_gate_q <=
                i_pwdata[interval_timer_pkg::BIT_TIMER_CLK_GATE];
        end
    end

    // supply cut only in deep stop or halt on subsystem clock
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_periph_sub_enable <= 1'b1;
        end else begin
            o_periph_sub_enable <=
                !(sub_supply_q[interval_timer_pkg::BIT_LOW_POWER_SUPPLY] &&
                  (pin_lvl[interval_timer_pkg::PIN_DEEP_STOP] ||
                   (pin_lvl[interval_timer_pkg::PIN_HALT] &&
                    pin_lvl[interval_timer_pkg::PIN_CPU_ON_SUB])));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timer control and block reset

    // Block reset bit; software pulses it high then low
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            block_reset_q <= interval_timer_pkg::RST_BLOCK_RESET;
        end else if (wr_hit(interval_timer_pkg::OFS_BLOCK_RESET)) begin
            block_reset_q <= i_pwdata[interval_timer_pkg::BIT_BLOCK_RESET];
        end
    end

    // Control register; block reset returns it to its reset value
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_ctrl_q <= interval_timer_pkg::RST_TIMER_CTRL;
        end else if (block_reset_q) begin
            timer_ctrl_q <= interval_timer_pkg::RST_TIMER_CTRL;
        end else if (wr_hit(interval_timer_pkg::OFS_TIMER_CTRL)) begin
            // Bits 14..12 are reserved and held at zero
            timer_ctrl_q <= {i_pwdata[interval_timer_pkg::BIT_TIMER_RUN],
                             3'h0,
                             i_pwdata[interval_timer_pkg::CMP_MSB:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter

    // stopped means cleared; wrap to zero after the match
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_q <= 12'h000;
            match_q <= 1'b0;
        end else if (!timer_run) begin
            count_q <= 12'h000;
            match_q <= 1'b0;
        end else if (count_tick) begin
            // period is compare plus one count edges
            if (count_q == cmp_value) begin
                count_q <= 12'h000;
                match_q <= 1'b1;
            end else begin
                count_q <= count_q + 12'h001;
                match_q <= 1'b0;
            end
        end else begin
            match_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt request flag and mask

    // flag set on match; set beats a software clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_irq_flag_q <= interval_timer_pkg::RST_IRQ_FLAG;
        end else if (match_q) begin
            timer_irq_flag_q <= 1'b1;
        end else if (wr_hit(interval_timer_pkg::OFS_IRQ_FLAG)) begin
            timer_irq_flag_q <= i_pwdata[interval_timer_pkg::BIT_TIMER_IRQ];
        end
    end

    // Mask register bit
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer_irq_mask_q <= interval_timer_pkg::RST_IRQ_MASK;
        end else if (wr_hit(interval_timer_pkg::OFS_IRQ_MASK)) begin
            timer_irq_mask_q <= i_pwdata[interval_timer_pkg::BIT_TIMER_IRQ];
        end
    end

    // mask blocks servicing only, never the flag
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_interval_interrupt <= 1'b0;
        end else begin
            o_interval_interrupt <= timer_irq_flag_q && !timer_irq_mask_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, clear and enable

    // Zero compare is illegal; flag it on each count edge while the timer runs with it
    assign evt_set[interval_timer_pkg::EVT_INTERVAL] = match_q;
    assign evt_set[interval_timer_pkg::EVT_CMP_ZERO] =
        timer_run && (cmp_value == 12'h000) && count_tick;

    // Written out, not through wr_hit: a continuous assign would not wake
    // on the bus signals that the function reads inside
    assign evt_clr =
        (wr_en && (i_paddr == interval_timer_pkg::OFS_EVT_CLEAR))
        ? i_pwdata[interval_timer_pkg::EVT_WIDTH-1:0]
        : '0;

    // Sticky bits; a new event wins over its clear
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evt_status_q <= '0;
        end else begin
            evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
        end
    end

    // Enable register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            evt_enable_q <= '0;
        end else if (wr_hit(interval_timer_pkg::OFS_EVT_ENABLE)) begin
            evt_enable_q <= i_pwdata[interval_timer_pkg::EVT_WIDTH-1:0];
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(evt_status_q & evt_enable_q);
        end
    end

endmodule // interval_timer

// ---- tb/interval_timer_properties.sv ----
// Port checker for interval_timer: APB handshake, mask, supply gating.
// Assumes it is bound into interval_timer and sees only its ports.
`timescale 1ns/1ps
module timer_props (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // APB side
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [31:0] o_prdata,
    input  wire logic        o_pready,
    input  wire logic        o_pslverr,
    // Power state and interrupt
    input  wire logic        i_deep_stop,
    input  wire logic        i_halt,
    input  wire logic        o_interval_interrupt,
    input  wire logic        o_periph_sub_enable
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    ////////////////////////////////////////////////////////////////////////
    // Setup cycle of any transfer
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    // Setup of a write that masks the timer request
    sequence s_mask_on;
        s_setup ##0 (i_pwrite && i_paddr == 8'h10 && i_pwdata[2]);
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (s_setup |=> o_pready)
        else $error("no ready after setup");
    a_ready_in_access: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready outside access");
    a_error_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("error without ready");
    a_unmapped_error: assert property (
        s_setup ##0 i_paddr > 8'h28 |=> o_pslverr)
        else $error("unmapped address accepted");
    a_idle_data_zero: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    // Mask lands at access edge, output one cycle later
    a_mask_blocks: assert property (
        s_mask_on |-> ##3 (!o_interval_interrupt) [*3])
        else $error("masked request still signalled");
    // Sync of two flops plus output register
    a_supply_awake: assert property (
        (!i_deep_stop && !i_halt) [*5] |-> o_periph_sub_enable)
        else $error("supply cut while awake");
    // Sticky flag: no bus access, no drop
    a_request_holds: assert property (
        $rose(o_interval_interrupt) && !i_psel |=> o_interval_interrupt)
        else $error("request dropped by itself");
endmodule // timer_props

bind interval_timer timer_props u_props (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_deep_stop(i_deep_stop), .i_halt(i_halt),
    .o_interval_interrupt(o_interval_interrupt),
    .o_periph_sub_enable(o_periph_sub_enable)
);

// ---- tb/tb_top.sv ----
// Self-checking bench for interval_timer over APB and its clock pins.
// Assumes the checker binds itself; clock 40 MHz, reset 12 cycles.
`timescale 1ns/1ps
module tb_top;
    logic        i_clk = 1'b0, i_rst_n = 1'b0;             // Clock, reset
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;                          // Byte address
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;           // Bus data
    logic        o_pready, o_pslverr, err, o_irq, o_interval_interrupt;
    logic        i_sub_clk = 1'b0, i_losc_clk = 1'b0, o_periph_sub_enable;
    logic        i_deep_stop = 1'b0, i_halt = 1'b0, i_cpu_on_sub = 1'b0;
    int          n_mismatch = 0, checks_done = 0;
    // Row: write first?, address, data, expected read, expected error
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, x; logic e;} row_s;
    row_s rows [11] = '{
        '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h10, 32'h0, 32'h4, 1'b0}, '{1'b0, 8'h14, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h18, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h28, 32'h0, 32'h0, 1'b0},
        '{1'b1, 8'h00, 32'h90, 32'h90, 1'b0}, '{1'b1, 8'h04, 32'h1, 32'h1, 1'b0},
        '{1'b1, 8'h14, 32'hFFFF, 32'h8FFF, 1'b0},
        '{1'b1, 8'h1C, 32'h3, 32'h0, 1'b0}, '{1'b1, 8'h2C, 32'h5, 32'h0, 1'b1}};

    interval_timer DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_sub_clk(i_sub_clk), .i_losc_clk(i_losc_clk),
        .i_deep_stop(i_deep_stop), .i_halt(i_halt), .i_cpu_on_sub(i_cpu_on_sub),
        .o_interval_interrupt(o_interval_interrupt), .o_irq(o_irq),
        .o_periph_sub_enable(o_periph_sub_enable));

    always #12.5 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////
    // One APB transfer; waits on pready, only the watchdog bounds it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // Compare one result, zero-extended flags included
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    // Rising edges on a count pin; slow so the sync sees each one
    task automatic tick(input logic osc, input int n);
        repeat (n) begin
            @(posedge i_clk);
            if (osc) i_losc_clk <= 1'b1; else i_sub_clk <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_losc_clk <= 1'b0;
            i_sub_clk <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        repeat (6) @(posedge i_clk);
    endtask
    // Power pins, then supply output after sync settles
    task automatic pwr(input logic s, h, c, x);
        i_deep_stop <= s;
        i_halt <= h;
        i_cpu_on_sub <= c;
        repeat (5) @(posedge i_clk);
        chk({31'h0, o_periph_sub_enable}, {31'h0, x});
    endtask
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        // oscillator source set only while sub pin is idle
        foreach (rows[k]) begin
            if (rows[k].w) apb(1'b1, rows[k].a, rows[k].d);
            apb(1'b0, rows[k].a, 32'h0);
            chk(rd, rows[k].x);
            chk({31'h0, err}, {31'h0, rows[k].e});
        end
        // Init order: block reset pulse, gate, stop, clear, enable, unmask, load
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h24, 32'h1);
        apb(1'b1, 8'h24, 32'h0);
        apb(1'b1, 8'h08, 32'h80);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h20, 32'h1);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h14, 32'h8003);
        tick(1'b0, 3);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        tick(1'b0, 1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h4);
        chk({31'h0, o_interval_interrupt}, 32'h1);
        chk({31'h0, o_irq}, 32'h1);
        tick(1'b0, 2);
        apb(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h2);
        apb(1'b1, 8'h10, 32'h4);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h4);
        chk({31'h0, o_interval_interrupt}, 32'h0);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h1C, 32'h1);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        // Gate off: no counting even while running
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b1, 8'h14, 32'h8FFF);
        tick(1'b0, 2);
        apb(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h08, 32'h80);
        tick(1'b0, 2);
        apb(1'b1, 8'h00, 32'h10);
        tick(1'b0, 2);
        tick(1'b1, 1);
        apb(1'b0, 8'h28, 32'h0);
        chk(rd, 32'h3);
        // Compare of one on the oscillator clock, then a forbidden zero
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h14, 32'h8001);
        tick(1'b1, 2);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, 8'h14, 32'h8000);
        tick(1'b1, 1);
        apb(1'b0, 8'h18, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b1, 8'h00, 32'h80);
        pwr(1'b0, 1'b1, 1'b0, 1'b1);
        pwr(1'b0, 1'b1, 1'b1, 1'b0);
        pwr(1'b1, 1'b0, 1'b0, 1'b0);
        apb(1'b1, 8'h00, 32'h0);
        pwr(1'b1, 1'b0, 1'b0, 1'b1);
        wrap_up();
    end
    // Watchdog well beyond the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        wrap_up();
    end
endmodule // tb_top
